// ==== core/clock_prescale_and_hard_reset.sv ====
// Master clock selection, prescaler, sample and data-rate dividers and hard reset.
`timescale 1ns/1ps
// Behaviour
// - In serial mode a low hard-reset pin holds the chip in reset.
// - During hard reset registers return to defaults and no access is accepted.
// - During hard reset internal clocks stop; only the input stage sees master clock.
// - Hard reset state equals the power-on reset state.
// - Bias stays on; with master clock running, operation resumes at release.
// - Without master clock during reset, early conversions are flagged unsettled.
// - In two-wire mode the reset pin is latched as ratio select bit zero.
// - Master clock comes from crystal when select is 0, clock pin when 1.
// - Two-bit prescale field divides master clock by 1, 2, 4 or 8.
// - The analog clock drives the gain amplifiers and modulators.
// - Sample clock is the analog clock divided by four.
// - Modulator outputs refresh once per sample clock period.
// - Output data rate is sample rate divided by the oversampling ratio.
// - Each new output word gives one data-ready pulse.
// - Three-bit ratio field selects 32 to 4096, default 256.
// - Data-ready pulse is low half a sample period, paced by master clock.
// - Interface mode input is latched after power-on, hard and watchdog reset.
module clock_prescale_and_hard_reset #(
	parameter int SETTLE_SAMPLES = clock_prescale_pkg::SETTLE_SAMPLES_DEFAULT
) (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic CRYSTAL_TICK,
	input wire logic CLOCK_INPUT_PIN,
	input wire logic HARD_RESET_N,
	input wire logic MODE_SELECT,
	input wire logic WATCHDOG_RESET,
	output logic MCLK_INPUT_TICK,
	output logic ANALOG_CLOCK_EN,
	output logic SAMPLE_CLOCK_EN,
	output logic OUTPUT_RATE_TICK,
	output logic DATA_READY_PIN_N,
	output logic BIAS_ENABLE,
	output logic CONVERSION_UNSETTLED,
	output logic TWO_WIRE_MODE,
	output logic IRQ
);
	import clock_prescale_pkg::*;

	// ----------------------------------------------------------------
	// Decoding helpers
	// ----------------------------------------------------------------
	function automatic logic [2:0] prescale_last(input logic [1:0] code);
		return 3'((1 << code) - 1);
	endfunction

	function automatic logic [11:0] ratio_last(input logic [2:0] code);
		return 12'((RATIO_BASE << code) - 1);
	endfunction

	function automatic logic [3:0] ready_last(input logic [1:0] code);
		return 4'(((SAMPLE_DIV / 2) << code) - 1);
	endfunction

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [CONFIG_BITS-1:0] cfg_r, cfg_nxt;
	logic [STATUS_BITS-1:0] status_r, status_nxt, mask_r, mask_nxt;
	logic [STATUS_BITS-1:0] cap_r, cap_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic err_r, err_nxt;
	logic clkin_d_r, hard_n_d_r, first_r;
	logic two_wire_r, two_wire_nxt, bit0_r, bit0_nxt;
	phase_e phase_r, phase_nxt;
	logic mclk_seen_r, mclk_seen_nxt;
	logic [15:0] settle_r, settle_nxt;
	logic [2:0] pre_cnt_r, pre_cnt_nxt;
	logic [1:0] ana_cnt_r, ana_cnt_nxt;
	logic [11:0] rate_cnt_r, rate_cnt_nxt;
	logic [3:0] ready_cnt_r, ready_cnt_nxt;
	logic ready_low_r, ready_low_nxt;
	logic mclk_tick, hr_active, hr_release, latch_evt, setup, access;
	logic analog_tick, sample_tick, out_tick;
	logic [1:0] pre_code;
	logic [2:0] ratio_eff;
	logic [15:0] settle_last;

	assign settle_last = 16'(SETTLE_SAMPLES - 1);

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);

	// ----------------------------------------------------------------
	// Clock selection and hard reset qualification
	// ----------------------------------------------------------------
	assign mclk_tick = cfg_r[EXTCLK_BIT] ? (CLOCK_INPUT_PIN & ~clkin_d_r) : CRYSTAL_TICK;
	assign hr_active = ~two_wire_r & ~HARD_RESET_N;
	assign hr_release = ~two_wire_r & HARD_RESET_N & ~hard_n_d_r;
	assign latch_evt = first_r | hr_release | WATCHDOG_RESET;
	assign pre_code = cfg_r[PRESCALE_LSB +: 2];
	assign ratio_eff = two_wire_r ? {cfg_r[RATIO_LSB+1 +: 2], bit0_r} : cfg_r[RATIO_LSB +: 3];

	always_comb begin
		two_wire_nxt = latch_evt ? MODE_SELECT : two_wire_r;
		bit0_nxt = (latch_evt & MODE_SELECT) ? HARD_RESET_N : bit0_r;
		phase_nxt = phase_r;
		mclk_seen_nxt = mclk_seen_r;
		settle_nxt = settle_r;
		case (phase_r)
			PH_RUN: begin
				if (hr_active) begin
					phase_nxt = PH_HELD;
					mclk_seen_nxt = 1'b0;
				end
			end
			PH_HELD: begin
				if (mclk_tick) begin
					mclk_seen_nxt = 1'b1;
				end
				if (!hr_active) begin
					phase_nxt = (mclk_seen_r | mclk_tick) ? PH_RUN : PH_SETTLE;
					settle_nxt = 16'h0000;
				end
			end
			PH_SETTLE: begin
				if (hr_active) begin
					phase_nxt = PH_HELD;
					mclk_seen_nxt = 1'b0;
				end else if (sample_tick) begin
					if (settle_r == settle_last) begin
						phase_nxt = PH_RUN;
					end else begin
						settle_nxt = settle_r + 16'h0001;
					end
				end
			end
			default: begin
				phase_nxt = PH_RUN;
			end
		endcase
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			clkin_d_r <= 1'b0;
			hard_n_d_r <= 1'b1;
			first_r <= 1'b1;
			two_wire_r <= 1'b0;
			bit0_r <= 1'b0;
			phase_r <= PH_RUN;
			mclk_seen_r <= 1'b0;
			settle_r <= 16'h0000;
		end else begin
			clkin_d_r <= CLOCK_INPUT_PIN;
			hard_n_d_r <= HARD_RESET_N;
			first_r <= 1'b0;
			two_wire_r <= two_wire_nxt;
			bit0_r <= bit0_nxt;
			phase_r <= phase_nxt;
			mclk_seen_r <= mclk_seen_nxt;
			settle_r <= settle_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Dividers
	// ----------------------------------------------------------------
	// Counters are held at zero under hard reset so that every divider restarts in phase.
	assign analog_tick = ~hr_active & mclk_tick & (pre_cnt_r == prescale_last(pre_code));
	assign sample_tick = analog_tick & (ana_cnt_r == 2'(SAMPLE_DIV - 1));
	assign out_tick = sample_tick & (rate_cnt_r == ratio_last(ratio_eff));

	always_comb begin
		pre_cnt_nxt = pre_cnt_r;
		ana_cnt_nxt = ana_cnt_r;
		rate_cnt_nxt = rate_cnt_r;
		ready_cnt_nxt = ready_cnt_r;
		ready_low_nxt = ready_low_r;
		if (hr_active) begin
			pre_cnt_nxt = 3'h0;
			ana_cnt_nxt = 2'h0;
			rate_cnt_nxt = 12'h000;
			ready_cnt_nxt = 4'h0;
			ready_low_nxt = 1'b0;
		end else begin
			if (mclk_tick) begin
				pre_cnt_nxt = analog_tick ? 3'h0 : pre_cnt_r + 3'h1;
			end
			if (analog_tick) begin
				ana_cnt_nxt = ana_cnt_r + 2'h1;
			end
			if (sample_tick) begin
				rate_cnt_nxt = out_tick ? 12'h000 : rate_cnt_r + 12'h001;
			end
			if (out_tick) begin
				ready_low_nxt = 1'b1;
				ready_cnt_nxt = ready_last(pre_code);
			end else if (ready_low_r && mclk_tick) begin
				if (ready_cnt_r == 4'h0) begin
					ready_low_nxt = 1'b0;
				end else begin
					ready_cnt_nxt = ready_cnt_r - 4'h1;
				end
			end
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			pre_cnt_r <= 3'h0;
			ana_cnt_r <= 2'h0;
			rate_cnt_r <= 12'h000;
			ready_cnt_r <= 4'h0;
			ready_low_r <= 1'b0;
			MCLK_INPUT_TICK <= 1'b0;
			ANALOG_CLOCK_EN <= 1'b0;
			SAMPLE_CLOCK_EN <= 1'b0;
			OUTPUT_RATE_TICK <= 1'b0;
		end else begin
			pre_cnt_r <= pre_cnt_nxt;
			ana_cnt_r <= ana_cnt_nxt;
			rate_cnt_r <= rate_cnt_nxt;
			ready_cnt_r <= ready_cnt_nxt;
			ready_low_r <= ready_low_nxt;
			MCLK_INPUT_TICK <= mclk_tick;
			ANALOG_CLOCK_EN <= analog_tick;
			SAMPLE_CLOCK_EN <= sample_tick;
			OUTPUT_RATE_TICK <= out_tick;
		end
	end

	assign DATA_READY_PIN_N = ~ready_low_r;
	assign BIAS_ENABLE = 1'b1;
	assign CONVERSION_UNSETTLED = (phase_r == PH_SETTLE);
	assign TWO_WIRE_MODE = two_wire_r;

	// ----------------------------------------------------------------
	// APB registers and interrupt
	// ----------------------------------------------------------------
	assign setup = PSEL & ~PENABLE;
	assign access = PSEL & PENABLE;
	assign PREADY = 1'b1;
	assign PRDATA = rdata_r;
	assign PSLVERR = access & err_r;
	assign IRQ = |(status_r & mask_r);

	always_comb begin
		cfg_nxt = cfg_r;
		mask_nxt = mask_r;
		rdata_nxt = rdata_r;
		err_nxt = err_r;
		cap_nxt = cap_r;
		status_nxt = status_r;
		if (access && !PWRITE && !err_r && PADDR == STATUS_OFFSET) begin
			status_nxt = status_r & ~cap_r;
		end
		status_nxt[ST_DATA_READY_BIT] = status_nxt[ST_DATA_READY_BIT] | out_tick;
		status_nxt[ST_RELEASE_BIT] = status_nxt[ST_RELEASE_BIT] | hr_release;
		if (setup) begin
			rdata_nxt = 32'h0000_0000;
			cap_nxt = STATUS_RESET;
			err_nxt = hr_active;
			case (PADDR)
				CONFIG_OFFSET: rdata_nxt[CONFIG_BITS-1:0] = cfg_r;
				STATUS_OFFSET: begin
					rdata_nxt[STATUS_BITS-1:0] = status_r;
					cap_nxt = status_r;
				end
				MASK_OFFSET: rdata_nxt[STATUS_BITS-1:0] = mask_r;
				STATE_OFFSET: begin
					rdata_nxt[STATE_TWO_WIRE_BIT] = two_wire_r;
					rdata_nxt[STATE_HELD_BIT] = hr_active;
					rdata_nxt[STATE_UNSETTLED_BIT] = (phase_r == PH_SETTLE);
					rdata_nxt[STATE_BIT0_LATCH_BIT] = bit0_r;
				end
				default: err_nxt = 1'b1;
			endcase
			if (hr_active) begin
				rdata_nxt = 32'h0000_0000;
			end
		end
		if (access && PWRITE && !err_r) begin
			if (PADDR == CONFIG_OFFSET) begin
				cfg_nxt = PWDATA[CONFIG_BITS-1:0];
			end
			if (PADDR == MASK_OFFSET) begin
				mask_nxt = PWDATA[STATUS_BITS-1:0];
			end
		end
		if (hr_active) begin
			cfg_nxt = CONFIG_RESET;
			mask_nxt = MASK_RESET;
			status_nxt = STATUS_RESET;
			cap_nxt = STATUS_RESET;
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			cfg_r <= CONFIG_RESET;
			mask_r <= MASK_RESET;
			status_r <= STATUS_RESET;
			cap_r <= STATUS_RESET;
			rdata_r <= 32'h0000_0000;
			err_r <= 1'b0;
		end else begin
			cfg_r <= cfg_nxt;
			mask_r <= mask_nxt;
			status_r <= status_nxt;
			cap_r <= cap_nxt;
			rdata_r <= rdata_nxt;
			err_r <= err_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence release_s;
		(phase_r == PH_HELD) ##1 (phase_r != PH_HELD);
	endsequence

	AST_HELD_DEFAULTS: assert property (hr_active |=> cfg_r == CONFIG_RESET && status_r == STATUS_RESET && mask_r == MASK_RESET) else $error("Registers not at default under hard reset.");
	AST_NO_ACCESS: assert property (setup && hr_active ##1 access |-> PSLVERR && PRDATA == 32'h0000_0000) else $error("Access accepted during hard reset.");
	AST_NO_CLOCKS: assert property (hr_active |=> !ANALOG_CLOCK_EN && !SAMPLE_CLOCK_EN && !OUTPUT_RATE_TICK) else $error("Clock distributed during hard reset.");
	AST_INPUT_CLOCK: assert property (hr_active && mclk_tick |=> MCLK_INPUT_TICK) else $error("Input stage lost master clock.");
	AST_RUN_AFTER: assert property (release_s |-> (phase_r == PH_RUN) || $past(!mclk_seen_r && !mclk_tick)) else $error("Not operational after release with clock.");
	AST_SETTLE: assert property (release_s |-> CONVERSION_UNSETTLED == $past(!mclk_seen_r && !mclk_tick)) else $error("Unsettled flag wrong after release.");
	AST_BIT0: assert property (latch_evt && MODE_SELECT |=> bit0_r == $past(HARD_RESET_N)) else $error("Ratio bit zero not latched from pin.");
	AST_PRESCALE: assert property (analog_tick && pre_code == 2'h3 |=> (!analog_tick) [*7]) else $error("Prescale divide wrong.");
	AST_SAMPLE_DIV: assert property (sample_tick |=> (!sample_tick) [*3]) else $error("Sample clock not analog clock over four.");
	AST_RATIO: assert property (out_tick |=> rate_cnt_r == 12'h000) else $error("Output rate counter did not wrap.");
	AST_READY_PULSE: assert property (out_tick |=> !DATA_READY_PIN_N && OUTPUT_RATE_TICK) else $error("Data ready pulse missing.");
	AST_MODE_LATCH: assert property (first_r |=> two_wire_r == $past(MODE_SELECT)) else $error("Mode not latched after reset.");
endmodule

// ==== core/clock_prescale_pkg.sv ====
// Constants, register map and types of the clock prescale and hard-reset block.
package clock_prescale_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [11:0] CONFIG_OFFSET = 12'h000;
	localparam logic [11:0] STATUS_OFFSET = 12'h004;
	localparam logic [11:0] MASK_OFFSET = 12'h008;
	localparam logic [11:0] STATE_OFFSET = 12'h00c;
	localparam int PRESCALE_LSB = 0;
	localparam int RATIO_LSB = 2;
	localparam int EXTCLK_BIT = 5;
	localparam int CONFIG_BITS = 6;
	localparam logic [5:0] CONFIG_RESET = 6'h2c;
	localparam int ST_DATA_READY_BIT = 0;
	localparam int ST_RELEASE_BIT = 1;
	localparam int STATUS_BITS = 2;
	localparam logic [1:0] STATUS_RESET = 2'h0;
	localparam logic [1:0] MASK_RESET = 2'h0;
	localparam int STATE_TWO_WIRE_BIT = 0;
	localparam int STATE_HELD_BIT = 1;
	localparam int STATE_UNSETTLED_BIT = 2;
	localparam int STATE_BIT0_LATCH_BIT = 3;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int SAMPLE_DIV = 4;
	localparam int RATIO_BASE = 32;
	localparam int SETTLE_SAMPLES_DEFAULT = 16;
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		PH_RUN = 3'b001,
		PH_HELD = 3'b010,
		PH_SETTLE = 3'b100
	} phase_e;
endpackage

// ==== verification/master_clock_source.sv ====
// Behavioural master clock source: crystal ticks and an external clock pin.
`timescale 1ns/1ps
module master_clock_source (
	input wire logic clk,
	input wire logic rst,
	input wire logic run,
	output logic crystal_tick,
	output logic pin
);
	// ----------------
	// Clock sources
	// ----------------
	// Both sources run together, so the select bit alone decides which one paces the block.
	// A stopped pin rests low instead of idling mid-period.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			crystal_tick <= 1'b0;
			pin <= 1'b0;
		end else begin
			crystal_tick <= run;
			pin <= run & ~pin;
		end
	end
endmodule

// ==== verification/clock_prescale_and_hard_reset_bench.sv ====
// Self-checking bench for the clock prescale and hard-reset block.
`timescale 1ns/1ps
module clock_prescale_and_hard_reset_bench;
	import clock_prescale_pkg::*;
	// ----------------
	// Signals
	// ----------------
	logic CLK_SYS, RST, PSEL, PENABLE, PWRITE, HARD_RESET_N, MODE_SELECT, WATCHDOG_RESET;
	logic [11:0] PADDR;
	logic [31:0] PWDATA, PRDATA;
	logic PREADY, PSLVERR, CRYSTAL_TICK, CLOCK_INPUT_PIN, MCLK_INPUT_TICK, ANALOG_CLOCK_EN;
	logic SAMPLE_CLOCK_EN, OUTPUT_RATE_TICK, DATA_READY_PIN_N, BIAS_ENABLE;
	logic CONVERSION_UNSETTLED, TWO_WIRE_MODE, IRQ, run;
	logic [2:0] evs;
	logic [32:0] exp_q[$];
	logic [32:0] e;
	logic [7:0] rnd;
	int err_total = 0;
	int total_checks = 0;
	int cycles = 0;
	int n;
	assign evs = {OUTPUT_RATE_TICK, SAMPLE_CLOCK_EN, ANALOG_CLOCK_EN};
	clock_prescale_and_hard_reset #(.SETTLE_SAMPLES(2)) u_clock_prescale_and_hard_reset (
		.CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.CRYSTAL_TICK(CRYSTAL_TICK), .CLOCK_INPUT_PIN(CLOCK_INPUT_PIN),
		.HARD_RESET_N(HARD_RESET_N), .MODE_SELECT(MODE_SELECT),
		.WATCHDOG_RESET(WATCHDOG_RESET), .MCLK_INPUT_TICK(MCLK_INPUT_TICK),
		.ANALOG_CLOCK_EN(ANALOG_CLOCK_EN), .SAMPLE_CLOCK_EN(SAMPLE_CLOCK_EN),
		.OUTPUT_RATE_TICK(OUTPUT_RATE_TICK), .DATA_READY_PIN_N(DATA_READY_PIN_N),
		.BIAS_ENABLE(BIAS_ENABLE), .CONVERSION_UNSETTLED(CONVERSION_UNSETTLED),
		.TWO_WIRE_MODE(TWO_WIRE_MODE), .IRQ(IRQ));
	master_clock_source u_master_clock_source (.clk(CLK_SYS), .rst(RST), .run(run),
		.crystal_tick(CRYSTAL_TICK), .pin(CLOCK_INPUT_PIN));
	initial begin
		CLK_SYS = 1'b0;
		forever #10 CLK_SYS = ~CLK_SYS;
	end
	// ----------------
	// Tasks
	// ----------------
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [32:0] x);
		exp_q.push_back(x);
		@(posedge CLK_SYS);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK_SYS);
		PENABLE <= 1'b1;
		do @(posedge CLK_SYS); while (PREADY !== 1'b1);
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	// Counts clock edges from one pulse of the chosen event to the next.
	task automatic span(input int k, input int x);
		int c;
		c = 0;
		@(posedge CLK_SYS);
		while (evs[k] !== 1'b1) @(posedge CLK_SYS);
		do begin
			@(posedge CLK_SYS);
			c++;
		end while (evs[k] !== 1'b1);
		check(c, x);
	endtask
	task automatic wdog();
		WATCHDOG_RESET <= 1'b1;
		@(posedge CLK_SYS);
		WATCHDOG_RESET <= 1'b0;
		repeat (3) @(posedge CLK_SYS);
	endtask
	// With r low the clock stops four cycles ahead of the hold so a late tick cannot count as present.
	task automatic hreset(input logic r);
		logic [2:0] a;
		logic m;
		a = 3'h0;
		m = 1'b0;
		run <= r;
		repeat (4) @(posedge CLK_SYS);
		HARD_RESET_N <= 1'b0;
		repeat (3) @(posedge CLK_SYS);
		apb(1'b0, CONFIG_OFFSET, 32'h0, 33'h100000000);
		repeat (40) begin
			@(posedge CLK_SYS);
			a = a | evs;
			m = m | MCLK_INPUT_TICK;
		end
		check(a, 0);
		check(m, r);
		check(BIAS_ENABLE, 1);
		HARD_RESET_N <= 1'b1;
		run <= 1'b1;
		repeat (2) @(posedge CLK_SYS);
		check(CONVERSION_UNSETTLED, !r);
		apb(1'b0, CONFIG_OFFSET, 32'h0, {27'h0, CONFIG_RESET});
		apb(1'b0, STATUS_OFFSET, 32'h0, 33'h2);
		repeat (100) @(posedge CLK_SYS);
		check(CONVERSION_UNSETTLED, 0);
		$display("test hard reset finished");
	endtask
	// ----------------
	// Checking and sequence
	// ----------------
	always @(posedge CLK_SYS) begin
		cycles++;
		if (cycles == 99000) begin
			err_total++;
			print_verdict();
		end
		if (PSEL && PENABLE && PREADY) begin
			e = exp_q.pop_front();
			if (PWRITE)
				check(PSLVERR, e[32]);
			else
				check({PSLVERR, PRDATA}, e);
		end
	end
	initial begin
		RST = 1'b1;
		{PSEL, PENABLE, PWRITE, WATCHDOG_RESET, MODE_SELECT} = 5'h0;
		{PADDR, PWDATA} = 44'h0;
		HARD_RESET_N = 1'b1;
		run = 1'b1;
		rnd = 8'h40;
		repeat (3) @(posedge CLK_SYS);
		RST <= 1'b0;
		apb(1'b0, CONFIG_OFFSET, 32'h0, {27'h0, CONFIG_RESET});
		apb(1'b0, STATUS_OFFSET, 32'h0, 33'h0);
		apb(1'b0, MASK_OFFSET, 32'h0, 33'h0);
		apb(1'b0, 12'h010, 32'h0, 33'h100000000);
		rnd = lfsr(rnd);
		apb(1'b1, MASK_OFFSET, {4{rnd}}, 33'h0);
		apb(1'b0, MASK_OFFSET, 32'h0, {31'h0, rnd[1:0]});
		for (int p = 0; p < 4; p++) begin
			apb(1'b1, CONFIG_OFFSET, 32'h20 | p, 33'h0);
			span(0, 2 << p);
			span(1, 8 << p);
			span(2, 256 << p);
			while (DATA_READY_PIN_N !== 1'b0) @(posedge CLK_SYS);
			n = 0;
			while (DATA_READY_PIN_N === 1'b0) begin
				@(posedge CLK_SYS);
				n++;
			end
			check(n, 4 << p);
		end
		$display("test prescale finished");
		hreset(1'b1);
		apb(1'b1, MASK_OFFSET, 32'h1, 33'h0);
		span(2, 2048);
		repeat (3) @(posedge CLK_SYS);
		check(IRQ, 1);
		apb(1'b0, STATUS_OFFSET, 32'h0, 33'h1);
		repeat (2) @(posedge CLK_SYS);
		check(IRQ, 0);
		apb(1'b1, MASK_OFFSET, 32'h0, 33'h0);
		span(2, 2048);
		repeat (3) @(posedge CLK_SYS);
		check(IRQ, 0);
		apb(1'b0, STATUS_OFFSET, 32'h0, 33'h1);
		$display("test interrupt finished");
		hreset(1'b0);
		apb(1'b1, CONFIG_OFFSET, 32'h20, 33'h0);
		MODE_SELECT <= 1'b1;
		wdog();
		check(TWO_WIRE_MODE, 1);
		span(2, 512);
		apb(1'b0, STATE_OFFSET, 32'h0, 33'h9);
		HARD_RESET_N <= 1'b0;
		wdog();
		span(2, 256);
		apb(1'b0, CONFIG_OFFSET, 32'h0, 33'h20);
		HARD_RESET_N <= 1'b1;
		MODE_SELECT <= 1'b0;
		wdog();
		check(TWO_WIRE_MODE, 0);
		$display("test two-wire finished");
		hreset(1'b1);
		for (int r = 0; r < 8; r++) begin
			apb(1'b1, CONFIG_OFFSET, r << 2, 33'h0);
			span(2, 128 << r);
		end
		$display("test ratio finished");
		print_verdict();
	end
endmodule
